// file: intc_pkg.sv
package intc_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int          NUM_SRC      = 8;   // Sources held in this block
  localparam int          NUM_PERIPH   = 4;   // Sources [7:4] count as peripheral
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 8;
  localparam int          PC_W         = 21;

  // ---------------------------------------------------------------
  // Vector addresses
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0] HIGH_VECTOR = 21'h000008;
  localparam logic [PC_W-1:0] LOW_VECTOR  = 21'h000018;

  // ---------------------------------------------------------------
  // Register map (byte offsets of the plain register port)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_FLAG   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PRIO   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATE  = 4'h4;

  // Control register bit positions
  localparam int          BIT_OVERALL  = 7;   // overall_or_high_level_enable
  localparam int          BIT_PERIPH   = 6;   // peripheral_or_low_level_enable
  localparam int          BIT_PRIOEN   = 5;   // priority_feature_enable
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

  // Latency from flag set to vector: three cycles, fixed regardless of opcode length
  localparam int          LATENCY_CYC  = 3;
  localparam logic [1:0]  LAT_LAST     = 2'h2;

  // Handler nesting states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW  = 3'b010,
    ST_HIGH = 3'b100
  } level_state_type;

endpackage : intc_pkg

// file: sync_flag.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// One event line: two-flop synchroniser, edge detect, sticky flag
// ---------------------------------------------------------------
module sync_flag (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Event and software clear
  input  wire logic event_pin,
  input  wire logic clear,
  // Flag
  output logic      flag
);
  logic meta;
  logic stable;
  logic stable_d;

  // Synchroniser; meta read only by stable
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta     <= 1'b0;
      stable   <= 1'b0;
      stable_d <= 1'b0;
    end else begin
      meta     <= event_pin;
      stable   <= meta;
      stable_d <= stable;
    end
  end

  // Set beats clear so an event in the clear cycle is kept
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (stable && !stable_d) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule : sync_flag

// file: intc_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Each source picks high or low; high vectors 0008h, low vectors 0018h.
// - Enabled high request pre-empts a running low handler and vectors again.
// - Each source has a flag, an enable and a priority select bit.
// - With priority feature clear (reset) priority selects are ignored.
// - Compatibility: peripheral sources need peripheral and overall enables both set.
// - Compatibility: overall enable alone gates core sources; clearing masks all.
// - Compatibility: every accepted interrupt vectors to 0008h.
// - Priority mode: high enable passes high sources; clear masks everything.
// - Priority mode: low sources need both high and low enables set.
// - Acceptance clears overall enable, or the accepted level's enable.
// - Low requests are not serviced while a high handler runs.
// - Vectoring pushes return address and loads the vector into PC.
// - Return instruction outside an acceptance cycle leaves the handler and sets the cleared enable again.
// - Pin event to vector latency is six cycles, fixed.
// - Flags set on events whatever the enable bits hold.
module intc_core
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Core and peripheral event pins
  input  wire logic [NUM_SRC-1:0] src_event,
  // Core side
  input  wire logic [PC_W-1:0]   core_pc,
  input  wire logic              core_return_from_handler_instruction,
  output logic                   vector_req,
  output logic      [PC_W-1:0]   vector_addr,
  output logic                   stack_push,
  output logic      [PC_W-1:0]   stack_data
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] flag;
  logic [NUM_SRC-1:0] enable;
  logic [NUM_SRC-1:0] prio;
  logic               overall_or_high_level_enable;
  logic               peripheral_or_low_level_enable;
  logic               priority_feature_enable;
  level_state_type    level_state;
  level_state_type    next_level_state;
  logic [1:0]         lat_cnt;
  logic [NUM_SRC-1:0] flag_clear;
  logic               wr_flag;
  logic               preempted_low;

  assign wr_flag    = reg_wr && (reg_addr == ADDR_FLAG);
  // Writing zero to a flag bit clears it; writing one leaves it
  assign flag_clear = wr_flag ? ~reg_wdata : '0;

  // ---------------------------------------------------------------
  // Source flags
  // ---------------------------------------------------------------
  // flags ignore enables
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    sync_flag u_flag (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .event_pin (src_event[i]),
      .clear     (flag_clear[i]),
      .flag      (flag[i])
    );
  end

  // ---------------------------------------------------------------
  // Gating
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] active;
  logic [NUM_SRC-1:0] periph_mask;
  logic               any_compat;
  logic               any_high;
  logic               any_low;
  logic               take_high;
  logic               take_low;
  logic               take_any;
  logic               pending;

  assign active      = flag & enable;
  assign periph_mask = {{NUM_PERIPH{1'b1}}, {(NUM_SRC-NUM_PERIPH){1'b0}}};

  assign any_compat = overall_or_high_level_enable &&
                      (|(active & ~periph_mask) ||
                       (peripheral_or_low_level_enable && |(active & periph_mask)));
  // priority bits only count in priority mode
  assign any_high   = overall_or_high_level_enable && |(active & prio);
  assign any_low    = overall_or_high_level_enable && peripheral_or_low_level_enable &&
                      |(active & ~prio);

  assign take_high = priority_feature_enable && any_high && (level_state != ST_HIGH) &&
                     (lat_cnt == LAT_LAST);
  assign take_low  = priority_feature_enable && !any_high && any_low &&
                     (level_state == ST_IDLE) && (lat_cnt == LAT_LAST);
  assign take_any  = take_high || take_low ||
                     (!priority_feature_enable && any_compat && (lat_cnt == LAT_LAST));

  // only a request this level could take arms the latency counter, so
  // a masked or blocked source cannot leave the count primed early
  assign pending = priority_feature_enable ?
                   ((any_high && (level_state != ST_HIGH)) ||
                    (any_low && (level_state == ST_IDLE))) : any_compat;

  // ---------------------------------------------------------------
  // Latency counter
  // ---------------------------------------------------------------
  // fixed wait after the flag, independent of the instruction
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lat_cnt <= 2'h0;
    end else if (take_any || !pending) begin
      lat_cnt <= 2'h0;
    end else if (lat_cnt != LAT_LAST) begin
      lat_cnt <= lat_cnt + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Handler level tracking
  // ---------------------------------------------------------------
  always_comb begin
    next_level_state = level_state;
    case (level_state)
      ST_IDLE: begin
        if (take_high) begin
          next_level_state = ST_HIGH;
        end else if (take_low) begin
          next_level_state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (take_high) begin
          next_level_state = ST_HIGH;
        end else if (core_return_from_handler_instruction) begin
          next_level_state = ST_IDLE;
        end
      end
      ST_HIGH: begin
        // A high handler that cut into a low one returns to it, so the
        // low handler's own return still restores the low enable
        if (core_return_from_handler_instruction) begin
          next_level_state = preempted_low ? ST_LOW : ST_IDLE;
        end
      end
      default: next_level_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      level_state <= ST_IDLE;
    end else begin
      level_state <= next_level_state;
    end
  end

  // remember a low handler that a high one cut into, so that the
  // high return goes back to it instead of dropping to idle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      preempted_low <= 1'b0;
    end else if (level_state == ST_LOW && take_high) begin
      preempted_low <= 1'b1;
    end else if (level_state == ST_HIGH && core_return_from_handler_instruction) begin
      preempted_low <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Global enables and mode
  // ---------------------------------------------------------------
  // acceptance clears enable
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overall_or_high_level_enable   <= CTRL_RESET[BIT_OVERALL];
      peripheral_or_low_level_enable <= CTRL_RESET[BIT_PERIPH];
      priority_feature_enable        <= CTRL_RESET[BIT_PRIOEN];
    end else if (take_any) begin
      if (take_low) begin
        peripheral_or_low_level_enable <= 1'b0;
      end else begin
        overall_or_high_level_enable   <= 1'b0;
      end
    end else if (core_return_from_handler_instruction) begin
      if (priority_feature_enable && level_state == ST_LOW) begin
        peripheral_or_low_level_enable <= 1'b1;
      end else begin
        overall_or_high_level_enable   <= 1'b1;
      end
    end else if (reg_wr && reg_addr == ADDR_CTRL) begin
      overall_or_high_level_enable   <= reg_wdata[BIT_OVERALL];
      peripheral_or_low_level_enable <= reg_wdata[BIT_PERIPH];
      priority_feature_enable        <= reg_wdata[BIT_PRIOEN];
    end
  end

  // ---------------------------------------------------------------
  // Enable and priority select registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      enable <= '0;
      prio   <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_ENABLE) begin
        enable <= reg_wdata;
      end
      if (reg_addr == ADDR_PRIO) begin
        prio <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Vectoring outputs
  // ---------------------------------------------------------------
  // Address and pushed value hold between acceptances; only the pulses mark one
  // vector by level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vector_req  <= 1'b0;
      vector_addr <= '0;
      stack_push  <= 1'b0;
      stack_data  <= '0;
    end else begin
      vector_req  <= take_any;
      stack_push  <= take_any;
      if (take_any) begin
        vector_addr <= take_low ? LOW_VECTOR : HIGH_VECTOR;
        stack_data  <= core_pc;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port: data in the cycle after the strobe, unmapped reads zero
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_FLAG:   reg_rdata <= flag;
        ADDR_ENABLE: reg_rdata <= enable;
        ADDR_PRIO:   reg_rdata <= prio;
        ADDR_CTRL:   reg_rdata <= {overall_or_high_level_enable,
                                   peripheral_or_low_level_enable,
                                   priority_feature_enable, 5'h00};
        ADDR_STATE:  reg_rdata <= {5'h00, level_state};
        default:     reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_HIGH_VEC: assert property (@(posedge mclk) disable iff (!rst_b)
    take_high |=> vector_req && vector_addr == HIGH_VECTOR)
    else $error("high request missed high vector");
  AST_LOW_VEC: assert property (@(posedge mclk) disable iff (!rst_b)
    take_low |=> vector_req && vector_addr == LOW_VECTOR)
    else $error("low request missed low vector");
  AST_COMPAT_VEC: assert property (@(posedge mclk) disable iff (!rst_b)
    (take_any && !priority_feature_enable) |=> vector_addr == HIGH_VECTOR)
    else $error("compat vector not high");
  AST_PREEMPT: assert property (@(posedge mclk) disable iff (!rst_b)
    (level_state == ST_LOW && take_high) |=> level_state == ST_HIGH)
    else $error("high did not pre-empt low");
  AST_NO_LOW_IN_HIGH: assert property (@(posedge mclk) disable iff (!rst_b)
    level_state == ST_HIGH |-> !take_low)
    else $error("low taken in high handler");
  AST_CLEAR_GIE: assert property (@(posedge mclk) disable iff (!rst_b)
    (take_any && !take_low) |=> !overall_or_high_level_enable)
    else $error("enable not cleared on accept");
  AST_CLEAR_LOW: assert property (@(posedge mclk) disable iff (!rst_b)
    take_low |=> !peripheral_or_low_level_enable)
    else $error("low enable not cleared");
  AST_PUSH: assert property (@(posedge mclk) disable iff (!rst_b)
    take_any |=> stack_push && stack_data == $past(core_pc))
    else $error("return address not pushed");
  AST_MASK: assert property (@(posedge mclk) disable iff (!rst_b)
    !overall_or_high_level_enable |-> !take_any)
    else $error("accept while masked");
  AST_HIGH_FIRST: assert property (@(posedge mclk) disable iff (!rst_b)
    (priority_feature_enable && any_high && any_low) |-> !take_low)
    else $error("low served before high");
  AST_LATENCY: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(any_compat && !priority_feature_enable && level_state == ST_IDLE)
      |-> ##[2:3] take_any)
    else $error("latency out of range");
  // Return path: each return with no acceptance in its cycle restores what its acceptance cleared
  AST_RET_HIGH: assert property (@(posedge mclk) disable iff (!rst_b)
    (core_return_from_handler_instruction && !take_any && !(priority_feature_enable && level_state == ST_LOW))
      |=> overall_or_high_level_enable)
    else $error("return left overall or high enable clear");
  AST_RET_LOW: assert property (@(posedge mclk) disable iff (!rst_b)
    (core_return_from_handler_instruction && !take_any && priority_feature_enable && level_state == ST_LOW)
      |=> peripheral_or_low_level_enable)
    else $error("return left low enable clear");
  AST_RET_NEST: assert property (@(posedge mclk) disable iff (!rst_b)
    (core_return_from_handler_instruction && level_state == ST_HIGH && preempted_low) |=> level_state == ST_LOW)
    else $error("high return did not resume low handler");
  AST_LAT_LEVEL: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(pending) ##1 pending ##1 pending |-> take_any)
    else $error("request not taken after latency count");
  AST_NO_LOW_VEC_IN_HIGH: assert property (@(posedge mclk) disable iff (!rst_b)
    level_state == ST_HIGH |=> !(vector_req && vector_addr == LOW_VECTOR))
    else $error("low vector issued in high handler");

  COV_HIGH: cover property (@(posedge mclk) disable iff (!rst_b) take_high);
  COV_LOW: cover property (@(posedge mclk) disable iff (!rst_b) take_low);
  COV_NEST: cover property (@(posedge mclk) disable iff (!rst_b)
    level_state == ST_LOW && take_high);
  COV_RET: cover property (@(posedge mclk) disable iff (!rst_b)
    core_return_from_handler_instruction && level_state != ST_IDLE);
  COV_BACK_TO_LOW: cover property (@(posedge mclk) disable iff (!rst_b)
    core_return_from_handler_instruction && level_state == ST_HIGH && preempted_low);

endmodule : intc_core

// file: core_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Processor core stand-in: program counter, return stack, return pulse
// ---------------------------------------------------------------
module core_model
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // From the controller
  input  wire logic              vector_req,
  input  wire logic [PC_W-1:0]   vector_addr,
  input  wire logic              stack_push,
  input  wire logic [PC_W-1:0]   stack_data,
  // From the bench
  input  wire logic              ret_req,
  // To the controller
  output logic      [PC_W-1:0]   core_pc,
  output logic                   core_return_from_handler_instruction
);
  logic [PC_W-1:0] ret_stack[$];

  // Jump on a vector, pop on return; the pc holds the vector value until then
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      core_pc     <= 21'h000100;
      core_return_from_handler_instruction <= 1'b0;
      ret_stack.delete();
    end else begin
      core_return_from_handler_instruction <= ret_req;
      if (stack_push === 1'b1) begin
        ret_stack.push_back(stack_data);
      end
      if (vector_req === 1'b1) begin
        core_pc <= vector_addr;
      end else if (ret_req && ret_stack.size() > 0) begin
        core_pc <= ret_stack.pop_back();
      end
    end
  end
endmodule : core_model

// file: tb_two_level_interrupt_priority_controller.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); end end
module tb_two_level_interrupt_priority_controller
  import intc_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic              mclk;
  logic              rst_b;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_SRC-1:0] src_event;
  logic [PC_W-1:0]   core_pc;
  logic              core_return_from_handler_instruction;
  logic              ret_req;
  logic              vector_req;
  logic [PC_W-1:0]   vector_addr;
  logic              stack_push;
  logic [PC_W-1:0]   stack_data;
  int                error_cnt;
  int                check_count;
  int                first_lat;
  logic [DATA_W-1:0] rd;
  bit                got;
  int                lat;
  logic              push_seen;

  typedef struct {
    logic [7:0] ctrl, en, prio, ev;
    bit exp_vec;
    logic [PC_W-1:0] addr;
    logic [7:0] ctrl_after;
  } row_type;
  row_type rows[9];

  intc_core dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
    .core_pc(core_pc), .core_return_from_handler_instruction(core_return_from_handler_instruction), .vector_req(vector_req),
    .vector_addr(vector_addr), .stack_push(stack_push), .stack_data(stack_data));

  core_model core_u (.mclk(mclk), .rst_b(rst_b), .vector_req(vector_req),
    .vector_addr(vector_addr), .stack_push(stack_push), .stack_data(stack_data),
    .ret_req(ret_req), .core_pc(core_pc), .core_return_from_handler_instruction(core_return_from_handler_instruction));

  // ---------------------------------------------------------------
  // Clock and bus tasks
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
  endtask : do_reset

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // Bounded wait for the vector pulse; lat counts edges from the request
  task automatic wait_vec(output bit g, output int l);
    g = 0; l = 0;
    for (int i = 1; i <= 12 && !g; i++) begin
      @(posedge mclk);
      #1 if (vector_req === 1'b1) begin g = 1; l = i; push_seen = stack_push; end
    end
  endtask : wait_vec

  task automatic fire(input logic [7:0] m);
    @(posedge mclk);
    src_event <= m;
    wait_vec(got, lat);
    @(posedge mclk);
    src_event <= 8'h00;
  endtask : fire

  task automatic do_ret();
    @(posedge mclk);
    ret_req <= 1'b1;
    @(posedge mclk);
    ret_req <= 1'b0;
  endtask : do_ret

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("unexpected at %0t: run limit", $time);
    finish_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    src_event = 8'h00; ret_req = 1'b0; error_cnt = 0; check_count = 0; first_lat = 0;
    rows = '{
      '{8'h80, 8'h01, 8'hFF, 8'h01, 1, HIGH_VECTOR, 8'h00},
      '{8'h80, 8'h01, 8'h00, 8'h01, 1, HIGH_VECTOR, 8'h00},
      '{8'h80, 8'h10, 8'h00, 8'h10, 0, HIGH_VECTOR, 8'h80},
      '{8'hC0, 8'h10, 8'h00, 8'h10, 1, HIGH_VECTOR, 8'h40},
      '{8'h40, 8'h01, 8'h00, 8'h01, 0, HIGH_VECTOR, 8'h40},
      '{8'hA0, 8'h10, 8'h10, 8'h10, 1, HIGH_VECTOR, 8'h20},
      '{8'hA0, 8'h01, 8'h00, 8'h01, 0, HIGH_VECTOR, 8'hA0},
      '{8'hE0, 8'h01, 8'h00, 8'h01, 1, LOW_VECTOR,  8'hA0},
      '{8'h60, 8'h01, 8'h01, 8'h01, 0, HIGH_VECTOR, 8'h60}};
    do_reset();
    reg_read(ADDR_CTRL, rd);  `CHK(rd, CTRL_RESET)
    reg_read(ADDR_STATE, rd); `CHK(rd, 8'h01)
    reg_read(4'h5, rd);       `CHK(rd, 8'h00)
    $display("test reset values done");
    // Gating table: one source, one control setting per row
    foreach (rows[k]) begin
      do_reset();
      reg_write(ADDR_PRIO, rows[k].prio);
      reg_write(ADDR_ENABLE, rows[k].en);
      reg_write(ADDR_CTRL, rows[k].ctrl);
      fire(rows[k].ev);
      `CHK(got, rows[k].exp_vec)
      if (rows[k].exp_vec) begin
        `CHK(vector_addr, rows[k].addr)
        `CHK(stack_data, 21'h000100)
        `CHK(push_seen, 1'b1)
        if (first_lat == 0) first_lat = lat;
        `CHK(lat, first_lat)
      end
      reg_read(ADDR_FLAG, rd); `CHK(rd, rows[k].ev)
      reg_read(ADDR_CTRL, rd); `CHK(rd, rows[k].ctrl_after)
      if (rows[k].exp_vec) begin
        reg_write(ADDR_FLAG, 8'h00);
        do_ret();
        reg_read(ADDR_CTRL, rd);  `CHK(rd, rows[k].ctrl)
        reg_read(ADDR_STATE, rd); `CHK(rd, 8'h01)
      end
    end
    `CHK(first_lat <= 7 && first_lat >= 3, 1'b1)
    $display("test gating table done");
    // Simultaneous high and low, then pre-emption of the low handler
    do_reset();
    reg_write(ADDR_PRIO, 8'h01);
    reg_write(ADDR_ENABLE, 8'h03);
    reg_write(ADDR_CTRL, 8'hE0);
    fire(8'h03);
    `CHK(got, 1'b1)
    `CHK(vector_addr, HIGH_VECTOR)
    // Re-enabling inside the high handler must still hold the low request
    reg_write(ADDR_CTRL, 8'hE0);
    wait_vec(got, lat); `CHK(got, 1'b0)
    reg_read(ADDR_STATE, rd); `CHK(rd, 8'h04)
    reg_write(ADDR_FLAG, 8'hFE);
    do_ret();
    wait_vec(got, lat); `CHK(got, 1'b1)
    `CHK(vector_addr, LOW_VECTOR)
    reg_read(ADDR_STATE, rd); `CHK(rd, 8'h02)
    fire(8'h01);
    `CHK(got, 1'b1)
    `CHK(vector_addr, HIGH_VECTOR)
    `CHK(stack_data, LOW_VECTOR)
    `CHK(lat, first_lat)
    // High return resumes the low handler, whose own return restores low
    reg_write(ADDR_FLAG, 8'hFE);
    do_ret();
    reg_read(ADDR_STATE, rd); `CHK(rd, 8'h02)
    reg_read(ADDR_CTRL, rd);  `CHK(rd, 8'hA0)
    reg_write(ADDR_FLAG, 8'hFD);
    do_ret();
    reg_read(ADDR_CTRL, rd);  `CHK(rd, 8'hE0)
    reg_read(ADDR_STATE, rd); `CHK(rd, 8'h01)
    $display("test priority nesting done");
    finish_test();
  end
endmodule : tb_two_level_interrupt_priority_controller
